// [design/ppc_pkg.sv]
// package of constants for the downstream port power control block
package ppc_pkg;
    localparam int NUM_PORTS = 3;
    localparam int FIRST_PORT = 2;
    localparam int FILT_W = 16;
    // over-current must stay low this long before it counts
    localparam int OC_FILTER_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [FILT_W-1:0] OC_FILTER_CYCLES = FILT_W'((OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [FILT_W-1:0] FILT_RESET = 16'h0000;
    localparam logic PORT_POWER_RESET = 1'b0;
endpackage : ppc_pkg

// [design/ppc_port_power.sv]
// per-port power enable and filtered over-current sense for downstream ports 2 to 4
//
// Contract
// - One shared power-enable and over-current-sense pin exists for each of downstream ports 2, 3 and 4.
// - A port whose power is off has its pin actively driven to logic 0.
// - The internal pull-up of a pin is switched off while that pin is driven low.
// - A powered port has its driver released and its pull-up on, so the pin is open drain and idles high.
// - The outside switch or fuse pulls the pin low on over-current, which the device reads as over-current while powered.
// - The sense input is evaluated only while the output driver is off.
// - The sense input is filtered so short low levels, such as power-up sag, are not reported.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_power
    import ppc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // hub control side
    input wire logic [NUM_PORTS-1:0] portPowerOn,
    input wire logic [NUM_PORTS-1:0] overcurrentClear,
    input wire logic [FILT_W-1:0] filterCycles,
    output logic [NUM_PORTS-1:0] overcurrentFlag,
    output logic [NUM_PORTS-1:0] overcurrentEvent,
    // pins: bit 0 is port 2, bit 2 is port 4
    input wire logic [NUM_PORTS-1:0] portPowerCtlPinIn,
    output logic [NUM_PORTS-1:0] portPowerCtlPinOut,
    output logic [NUM_PORTS-1:0] portPowerCtlPinOe,
    output logic [NUM_PORTS-1:0] portPowerCtlPullupEn
);

    ////////////////////////////////////////////////////////////////////////////
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic powerOn_q;
            logic senseMeta_q;
            logic senseSync_q;
            logic [FILT_W-1:0] lowCount_q;
            logic [FILT_W-1:0] lowCount_d;
            logic flag_q;
            logic senseLow;
            logic filterDone;
            logic newEvent;

            // registered so pin drive never glitches with the control input
            always_ff @(posedge clock) begin
                if (reset) begin
                    powerOn_q <= PORT_POWER_RESET;
                end else begin
                    powerOn_q <= portPowerOn[p];
                end
            end

            assign portPowerCtlPinOut[p] = 1'b0;
            assign portPowerCtlPinOe[p] = ~powerOn_q;
            assign portPowerCtlPullupEn[p] = powerOn_q;

            // two-stage synchroniser on the schmitt input
            always_ff @(posedge clock) begin
                if (reset) begin
                    senseMeta_q <= 1'b1;
                    senseSync_q <= 1'b1;
                end else begin
                    senseMeta_q <= portPowerCtlPinIn[p];
                    senseSync_q <= senseMeta_q;
                end
            end

            // low only counts while the driver is released
            assign senseLow = ~senseSync_q & powerOn_q;
            // zero threshold treated as one so a flag never fires on reset
            assign filterDone = (lowCount_q >= filterCycles) && (lowCount_q != 16'h0000);
            assign lowCount_d = !senseLow ? FILT_RESET : (filterDone ? lowCount_q : lowCount_q + 16'h0001);
            assign newEvent = filterDone & ~flag_q;

            always_ff @(posedge clock) begin
                if (reset) begin
                    lowCount_q <= FILT_RESET;
                end else begin
                    lowCount_q <= lowCount_d;
                end
            end

            // set wins over clear in the same cycle
            always_ff @(posedge clock) begin
                if (reset) begin
                    flag_q <= 1'b0;
                end else if (filterDone) begin
                    flag_q <= 1'b1;
                end else if (overcurrentClear[p]) begin
                    flag_q <= 1'b0;
                end
            end

            always_ff @(posedge clock) begin
                if (reset) begin
                    overcurrentEvent[p] <= 1'b0;
                end else begin
                    overcurrentEvent[p] <= newEvent;
                end
            end

            assign overcurrentFlag[p] = flag_q;
        end
    endgenerate

endmodule : ppc_port_power
`default_nettype wire

// [verif/ppc_port_power_properties.sv]
// assertions on port power pins and flags
`timescale 1ns/1ps
`default_nettype none
module ppc_port_power_properties import ppc_pkg::*; (
    input wire logic clock, reset,
    input wire logic [NUM_PORTS-1:0] portPowerOn, overcurrentClear, overcurrentFlag, overcurrentEvent,
    input wire logic [NUM_PORTS-1:0] portPowerCtlPinIn, portPowerCtlPinOut, portPowerCtlPinOe, portPowerCtlPullupEn,
    input wire logic [FILT_W-1:0] filterCycles);
default clocking @(posedge clock); endclocking
default disable iff (reset);
// bench runs filterCycles at 4
sequence lowRun; (portPowerCtlPullupEn[0] && !portPowerCtlPinIn[0]) [*8]; endsequence
a_off_drives_low: assert property (!$past(reset) |-> portPowerCtlPinOe == ~$past(portPowerOn))
    else $error("drive");
a_pullup_opposes: assert property (portPowerCtlPullupEn == ~portPowerCtlPinOe)
    else $error("pullup");
a_out_low: assert property (portPowerCtlPinOut == '0)
    else $error("out");
a_event_rise: assert property (overcurrentEvent == (overcurrentFlag & ~$past(overcurrentFlag)))
    else $error("event");
a_flag_sticky: assert property ((($past(overcurrentFlag) & ~overcurrentFlag) & ~$past(overcurrentClear)) == '0)
    else $error("sticky");
a_filter_low: assert property (overcurrentEvent[0] |-> $past(!portPowerCtlPinIn[0], 4) && $past(!portPowerCtlPinIn[0], 7))
    else $error("filter");
a_low_flags: assert property (lowRun |=> overcurrentFlag[0])
    else $error("flag");
a_reset_state: assert property ($fell(reset) |-> portPowerCtlPinOe == '1 && overcurrentFlag == '0)
    else $error("reset");
endmodule : ppc_port_power_properties
bind ppc_port_power ppc_port_power_properties PROPS (.*);
`default_nettype wire

// [verif/ppc_switch_model.sv]
// far-side power switch model
`timescale 1ns/1ps
`default_nettype none
module ppc_switch_model (input wire logic [2:0] oe, fault, output logic [2:0] pin);
    assign pin = ~(oe | fault); // pull-up holds high unless driven or faulted
endmodule : ppc_switch_model
`default_nettype wire

// [verif/tb.sv]
// bench for port power control
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 0, reset = 1;
    logic [2:0] on = 0, clr = 0, fault = 0, flag, ev, oe, pu, pout, pin;
    logic [15:0] filt = 16'h0004;
    int miscompares = 0, comparisons = 0, cyc = 0;
    initial forever #5 clock = ~clock;
    ppc_port_power DUT (.clock, .reset, .portPowerOn(on), .overcurrentClear(clr), .filterCycles(filt),
        .overcurrentFlag(flag), .overcurrentEvent(ev), .portPowerCtlPinIn(pin), .portPowerCtlPinOut(pout),
        .portPowerCtlPinOe(oe), .portPowerCtlPullupEn(pu));
    ppc_switch_model SW (.oe, .fault, .pin);
    // caller waits 1ns past the edge so registered outputs have settled
    task automatic chk(logic [2:0] g, e);
        comparisons++;
        if (g !== e) begin miscompares++; $display("Error %0t got %h expected %h", $time, g, e); end
    endtask : chk
    task w(int n); repeat (n) @(posedge clock); endtask : w
    task end_of_test;
        $display("%0d compares, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    always @(posedge clock) if (++cyc == 500) begin miscompares++; end_of_test; end
    task test_power_on;
        on <= 3'h5; w(2); #1;
        chk(oe, 3'h2);
        chk(pu, 3'h5);
        chk(pout, 3'h0);
        $display("power on done");
    endtask : test_power_on
    task test_glitch;
        w(1); fault <= 3'h1; w(3); fault <= 0; w(8); #1;
        chk(flag, 3'h0);
        chk(ev, 3'h0);
        $display("glitch done");
    endtask : test_glitch
    task test_fault;
        w(1); fault <= 3'h3; w(7); #1;
        chk(ev, 3'h1);
        w(3); #1;
        chk(flag, 3'h1);
        chk(ev, 3'h0);
        $display("fault done");
    endtask : test_fault
    task test_clear;
        w(1); fault <= 0; w(3); #1;
        chk(flag, 3'h1);
        w(1); clr <= 3'h1; w(1); clr <= 0; w(2); #1;
        chk(flag, 3'h0);
        $display("clear done");
    endtask : test_clear
    task test_power_off;
        w(1); on <= 0; w(2); #1;
        chk(oe, 3'h7);
        chk(pu, 3'h0);
        $display("power off done");
    endtask : test_power_off
    initial begin
        w(16); reset <= 0;
        test_power_on;
        test_glitch;
        test_fault;
        test_clear;
        test_power_off;
        end_of_test;
    end
endmodule : tb
`default_nettype wire
